// File: core/fwd_ctrl_pkg.sv
// constants, register map and frame carriers for the unknown-frame forward control block
// assumes a 250 MHz pclk and an apb master with 32-bit data
package fwd_ctrl_pkg;
   // clock rate in kHz, so that ms * kHz gives cycles
   localparam int CLK_KHZ = 250000;
   localparam int UNIT_16_MS = 16;
   localparam int UNIT_64_MS = 64;
   localparam int UNIT_256_MS = 256;
   localparam int CYCLES_16_MS = UNIT_16_MS * CLK_KHZ;
   localparam int CYCLES_64_MS = UNIT_64_MS * CLK_KHZ;
   localparam int CYCLES_256_MS = UNIT_256_MS * CLK_KHZ;
   localparam int PERIOD_W = 27;

   localparam int ADDR_W = 12;
   localparam int PORTS = 5;
   localparam int SRC_W = 3;
   localparam int TOS_W = 8;
   localparam int MAC_W = 48;
   localparam int PRIO_W = 2;

   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_UNKNOWN_MCAST = 10'h084;
   localparam logic [9:0] IDX_UNKNOWN_VID = 10'h085;
   localparam logic [9:0] IDX_SELF_IPMC = 10'h086;
   localparam logic [9:0] IDX_RATE_TAG = 10'h087;
   localparam logic [9:0] IDX_DSCP_BASE = 10'h090;
   localparam int DSCP_REGS = 16;
   localparam logic [9:0] IDX_DSCP_LAST = 10'h09F;

   // field positions
   localparam int FWD_EN_BIT = 5;
   localparam int MAP_LSB = 0;
   localparam int MAP_RSVD_BIT = 3;
   localparam int SELF_EN_BIT = 6;
   localparam int PERIOD_LSB = 4;
   localparam int QUEUE_RATE_BIT = 3;
   localparam int TAG_SEL_BIT = 2;
   localparam logic [4:0] MAP_PORT_MASK = 5'h17;

   // reset values and writable masks
   localparam logic [7:0] RST_UNKNOWN_MCAST = 8'h40;
   localparam logic [7:0] RST_UNKNOWN_VID = 8'h00;
   localparam logic [7:0] RST_SELF_IPMC = 8'h00;
   localparam logic [7:0] RST_RATE_TAG = 8'h10;
   localparam logic [7:0] RST_DSCP = 8'h00;
   localparam logic [7:0] WR_UNKNOWN_MCAST = 8'h37;
   localparam logic [7:0] WR_UNKNOWN_VID = 8'h37;
   localparam logic [7:0] WR_SELF_IPMC = 8'h77;
   localparam logic [7:0] WR_RATE_TAG = 8'h3C;
   localparam logic [7:0] WR_DSCP = 8'hFF;

   typedef enum logic [1:0] {
      cls_known,
      cls_unknown_mcast,
      cls_unknown_vid,
      cls_unknown_ip_mcast
   } frame_class_type;

   typedef struct packed {
      logic valid;
      frame_class_type cls;
      logic [SRC_W-1:0] src_port;
      logic [MAC_W-1:0] dst_mac;
      logic [TOS_W-1:0] tos;
      logic [PORTS-1:0] default_map;
   } frame_req_type;

   typedef struct packed {
      logic valid;
      logic [PORTS-1:0] fwd_map;
      logic [PRIO_W-1:0] prio;
      logic [PORTS-1:0] tag_insert;
      logic self_dropped;
   } frame_resp_type;
endpackage : fwd_ctrl_pkg

// File: core/rate_period_tick.sv
// ingress rate-limit unit period tick generator
// assumes the select comes from a register on the same clock
`timescale 1ns/100ps
module rate_period_tick
   import fwd_ctrl_pkg::*;
#(
   parameter logic [PERIOD_W-1:0] CYC_16 = PERIOD_W'(CYCLES_16_MS),
   parameter logic [PERIOD_W-1:0] CYC_64 = PERIOD_W'(CYCLES_64_MS),
   parameter logic [PERIOD_W-1:0] CYC_256 = PERIOD_W'(CYCLES_256_MS)
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // period select and tick
   input wire logic [1:0] period_sel,
   output logic tick
);
   logic [PERIOD_W-1:0] count;
   logic [1:0] last_sel;
   wire logic [PERIOD_W-1:0] target;
   wire logic restart;
   wire logic at_end;

   // upper bit set means 256 ms whatever the lower bit
   assign target = period_sel[1] ? CYC_256 : (period_sel[0] ? CYC_64 : CYC_16);
   assign restart = last_sel != period_sel;
   assign at_end = count >= target - PERIOD_W'(1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
         last_sel <= 2'h1;
         tick <= 1'b0;
      end else begin
         last_sel <= period_sel;
         tick <= at_end && !restart;
         count <= (restart || at_end) ? '0 : count + PERIOD_W'(1);
      end
   end

   period_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
      count < target || restart) else $error("period counter ran past its target");
endmodule : rate_period_tick

// File: core/fwd_ctrl_regs.sv
// unknown-frame forward control: apb register bank and per-frame forwarding decision
// assumes an apb master on pclk and a forwarding engine that presents one frame per request
//
// Notes on behaviour
// - zero map filters unknown multicast; each bit except bit 3 forwards to a port, port 1 lowest.
// - bit 3 of every unknown-frame map is reserved and never selects a port.
// - bit 5 of the unknown VLAN register enables unknown VLAN forwarding; reset zero.
// - unknown VLAN map zero filters; set bits forward; all ones broadcasts.
// - bit 6 of the self-address register enables own-address filtering; reset zero.
// - own-address frames are dropped at egress by comparing with the own address.
// - bit 5 of the IP multicast register enables unknown IP multicast forwarding.
// - unknown IP multicast map zero filters; set bits forward; all ones broadcasts.
// - period field 00 is 16 ms, 01 is 64 ms, 1x is 256 ms; reset 01.
// - bit 3 selects queue-based egress rate limiting; clear means port-based.
// - bit 2 set: per-source tag insertion from each egress port's eighth register.
// - bit 2 clear: tag insertion from bit 2 of each port's first register.
// - upper six TOS bits decode into one of 64 priority table entries.
// - bit 5 of the multicast register enables unknown non-IP multicast forwarding.
// - each two-bit table entry gives the priority for its code.
`timescale 1ns/100ps
module fwd_ctrl_regs
   import fwd_ctrl_pkg::*;
#(
   parameter logic [PERIOD_W-1:0] CYC_16 = PERIOD_W'(CYCLES_16_MS),
   parameter logic [PERIOD_W-1:0] CYC_64 = PERIOD_W'(CYCLES_64_MS),
   parameter logic [PERIOD_W-1:0] CYC_256 = PERIOD_W'(CYCLES_256_MS)
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // own address and per-port tag settings
   input wire logic [MAC_W-1:0] own_mac,
   input wire logic [PORTS-1:0][PORTS-1:0] tag_by_source,
   input wire logic [PORTS-1:0] tag_by_port,
   // frame decision
   input wire fwd_ctrl_pkg::frame_req_type req,
   output fwd_ctrl_pkg::frame_resp_type resp,
   // rate limit settings
   output logic queue_based_rate,
   output logic rate_period_pulse
);
   import fwd_ctrl_pkg::*;

   logic [7:0] unknown_multicast_forward_control;
   logic [7:0] unknown_vid_forward_control;
   logic [7:0] self_filter_ip_multicast_control;
   logic [7:0] rate_limit_tag_insert_control;
   logic [DSCP_REGS-1:0][7:0] dscp_table;

   // apb decode
   wire logic [9:0] idx = paddr[ADDR_W-1:2];
   wire logic aligned = paddr[1:0] == 2'h0;
   wire logic hit_mcast = aligned && idx == IDX_UNKNOWN_MCAST;
   wire logic hit_vid = aligned && idx == IDX_UNKNOWN_VID;
   wire logic hit_self = aligned && idx == IDX_SELF_IPMC;
   wire logic hit_rate = aligned && idx == IDX_RATE_TAG;
   wire logic hit_dscp = aligned && idx >= IDX_DSCP_BASE && idx <= IDX_DSCP_LAST;
   wire logic [3:0] dscp_idx = 4'(idx - IDX_DSCP_BASE);
   wire logic mapped = hit_mcast || hit_vid || hit_self || hit_rate || hit_dscp;
   wire logic setup = psel && !penable;
   wire logic wr_ok = psel && penable && pready && pwrite && !pslverr && pstrb[0];
   wire logic [7:0] wbyte = pwdata[7:0];
   wire logic [7:0] rd_byte = hit_mcast ? unknown_multicast_forward_control :
                              hit_vid ? unknown_vid_forward_control :
                              hit_self ? self_filter_ip_multicast_control :
                              hit_rate ? rate_limit_tag_insert_control :
                              hit_dscp ? dscp_table[dscp_idx] : 8'h00;

   // merge of written bits with fixed reserved values
   function automatic logic [7:0] merge(input logic [7:0] rst, input logic [7:0] mask,
                                        input logic [7:0] data);
      merge = (rst & ~mask) | (data & mask);
   endfunction : merge

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= setup;
         pslverr <= setup && !mapped;
         prdata <= setup ? {24'h000000, rd_byte} : prdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unknown_multicast_forward_control <= RST_UNKNOWN_MCAST;
         unknown_vid_forward_control <= RST_UNKNOWN_VID;
         self_filter_ip_multicast_control <= RST_SELF_IPMC;
         rate_limit_tag_insert_control <= RST_RATE_TAG;
      end else if (wr_ok) begin
         if (hit_mcast) begin
            unknown_multicast_forward_control <= merge(RST_UNKNOWN_MCAST, WR_UNKNOWN_MCAST, wbyte);
         end
         if (hit_vid) begin
            unknown_vid_forward_control <= merge(RST_UNKNOWN_VID, WR_UNKNOWN_VID, wbyte);
         end
         if (hit_self) begin
            self_filter_ip_multicast_control <= merge(RST_SELF_IPMC, WR_SELF_IPMC, wbyte);
         end
         if (hit_rate) begin
            rate_limit_tag_insert_control <= merge(RST_RATE_TAG, WR_RATE_TAG, wbyte);
         end
      end
   end

   // priority table, one register per four codes
   genvar gi;
   generate
      for (gi = 0; gi < DSCP_REGS; gi++) begin : g_dscp
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               dscp_table[gi] <= RST_DSCP;
            end else if (wr_ok && hit_dscp && dscp_idx == 4'(gi)) begin
               dscp_table[gi] <= merge(RST_DSCP, WR_DSCP, wbyte);
            end
         end
      end
   endgenerate

   // control fields
   wire logic mcast_en = unknown_multicast_forward_control[FWD_EN_BIT];
   wire logic vid_en = unknown_vid_forward_control[FWD_EN_BIT];
   wire logic ipmc_en = self_filter_ip_multicast_control[FWD_EN_BIT];
   wire logic self_en = self_filter_ip_multicast_control[SELF_EN_BIT];
   wire logic tag_sel = rate_limit_tag_insert_control[TAG_SEL_BIT];
   wire logic [1:0] period_sel = rate_limit_tag_insert_control[PERIOD_LSB +: 2];
   // reserved bit 3 never reaches the port map
   wire logic [PORTS-1:0] mcast_map =
      unknown_multicast_forward_control[MAP_LSB +: PORTS] & MAP_PORT_MASK;
   wire logic [PORTS-1:0] vid_map =
      unknown_vid_forward_control[MAP_LSB +: PORTS] & MAP_PORT_MASK;
   wire logic [PORTS-1:0] ipmc_map =
      self_filter_ip_multicast_control[MAP_LSB +: PORTS] & MAP_PORT_MASK;

   // frame decision
   wire logic self_hit = self_en && req.dst_mac == own_mac;
   logic [PORTS-1:0] class_map;
   always_comb begin
      class_map = req.default_map;
      case (req.cls)
         cls_known: class_map = req.default_map;
         cls_unknown_mcast: class_map = mcast_en ? mcast_map : req.default_map;
         cls_unknown_vid: class_map = vid_en ? vid_map : req.default_map;
         cls_unknown_ip_mcast: class_map = ipmc_en ? ipmc_map : req.default_map;
         default: class_map = req.default_map;
      endcase
   end
   wire logic [PORTS-1:0] next_map = self_hit ? '0 : (class_map & MAP_PORT_MASK);
   // six upper tos bits: four high select the register, two low the field
   wire logic [5:0] dscp_code = req.tos[TOS_W-1 -: 6];
   wire logic [7:0] dscp_byte = dscp_table[dscp_code[5:2]];
   wire logic [PRIO_W-1:0] next_prio = dscp_byte[{dscp_code[1:0], 1'b0} +: PRIO_W];
   logic [PORTS-1:0] next_tag;
   generate
      for (gi = 0; gi < PORTS; gi++) begin : g_tag
         always_comb begin
            next_tag[gi] = tag_sel ? tag_by_source[gi][req.src_port] : tag_by_port[gi];
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resp <= '0;
         queue_based_rate <= 1'b0;
      end else begin
         resp.valid <= req.valid;
         resp.fwd_map <= req.valid ? next_map : resp.fwd_map;
         resp.prio <= req.valid ? next_prio : resp.prio;
         resp.tag_insert <= req.valid ? next_tag : resp.tag_insert;
         resp.self_dropped <= req.valid && self_hit;
         queue_based_rate <= rate_limit_tag_insert_control[QUEUE_RATE_BIT];
      end
   end

   rate_period_tick #(
      .CYC_16(CYC_16),
      .CYC_64(CYC_64),
      .CYC_256(CYC_256)
   ) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .period_sel(period_sel),
      .tick(rate_period_pulse)
   );

   // checks
   sequence apb_setup_s;
      psel && !penable;
   endsequence
   sequence apb_access_s;
      psel && penable && pready;
   endsequence

   apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      apb_setup_s |=> pready ##1 !pready) else $error("apb ready not one cycle after setup");
   map_bit_three_a: assert property (@(posedge pclk) disable iff (!presetn)
      resp.valid |-> !resp.fwd_map[MAP_RSVD_BIT]) else $error("reserved map bit selected a port");
   mcast_forward_a: assert property (@(posedge pclk) disable iff (!presetn)
      req.valid && req.cls == cls_unknown_mcast && !self_hit |=>
      resp.fwd_map == ($past(mcast_en) ? ($past(unknown_multicast_forward_control[4:0]) & 5'h17)
                                      : ($past(req.default_map) & 5'h17)))
      else $error("unknown multicast map not applied");
   vid_forward_a: assert property (@(posedge pclk) disable iff (!presetn)
      req.valid && req.cls == cls_unknown_vid && vid_en && unknown_vid_forward_control[4:0] == 5'h00
      |=> resp.valid && resp.fwd_map == 5'h00) else $error("unknown vid frame not filtered");
   ipmc_forward_a: assert property (@(posedge pclk) disable iff (!presetn)
      req.valid && req.cls == cls_unknown_ip_mcast && !ipmc_en && !self_hit
      |=> resp.fwd_map == ($past(req.default_map) & 5'h17)) else $error("ip multicast map leaked");
   self_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
      req.valid && self_filter_ip_multicast_control[6] && req.dst_mac == own_mac
      |=> resp.self_dropped && resp.fwd_map == 5'h00) else $error("own-address frame forwarded");
   prio_lookup_a: assert property (@(posedge pclk) disable iff (!presetn)
      req.valid |=> resp.prio == $past(dscp_table[req.tos[7:4]][{req.tos[3:2], 1'b0} +: 2]))
      else $error("priority not taken from table");
   tag_select_a: assert property (@(posedge pclk) disable iff (!presetn)
      req.valid && !rate_limit_tag_insert_control[2] |=> resp.tag_insert == $past(tag_by_port))
      else $error("port tag setting not used");
   reserved_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
      apb_access_s and hit_rate |=> rate_limit_tag_insert_control[7:6] == 2'h0
      && rate_limit_tag_insert_control[1:0] == 2'h0) else $error("reserved bits changed");
   queue_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(rate_limit_tag_insert_control[3]) |=> queue_based_rate) else $error("queue mode late");
endmodule : fwd_ctrl_regs

// File: sim/test_fwd_ctrl_regs.sv
// self-checking bench for the unknown-frame forward control register bank
// assumes fwd_ctrl_pkg is compiled first; shortened period counts for simulation
`timescale 1ns/100ps
module test_fwd_ctrl_regs;
   import fwd_ctrl_pkg::*;
   typedef struct packed {logic rd; logic err; logic [7:0] data;} apb_note_type;
   localparam int P16 = 8;
   localparam int P64 = 16;
   localparam int P256 = 32;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [MAC_W-1:0] own_mac = '0;
   logic [PORTS-1:0][PORTS-1:0] tag_by_source = '0;
   logic [PORTS-1:0] tag_by_port = '0;
   frame_req_type req = '0;
   frame_resp_type resp;
   logic queue_based_rate;
   logic rate_period_pulse;
   // shadow of register bytes, indexed by the low five bits of the register index
   logic [7:0] sh [0:31];
   apb_note_type note_q [$];
   frame_resp_type resp_q [$];
   int per_q [$];
   int num_errors = 0;
   int compares = 0;
   int cnt = 0;
   int rnd;
   apb_note_type n;
   frame_resp_type e;

   fwd_ctrl_regs #(.CYC_16(PERIOD_W'(P16)), .CYC_64(PERIOD_W'(P64)), .CYC_256(PERIOD_W'(P256)))
   dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .own_mac(own_mac), .tag_by_source(tag_by_source),
      .tag_by_port(tag_by_port), .req(req), .resp(resp), .queue_based_rate(queue_based_rate),
      .rate_period_pulse(rate_period_pulse));

   always #2 pclk = ~pclk;

   function automatic logic [7:0] wmask(input logic [4:0] k);
      case (k)
         5'h04: return WR_UNKNOWN_MCAST;
         5'h05: return WR_UNKNOWN_VID;
         5'h06: return WR_SELF_IPMC;
         5'h07: return WR_RATE_TAG;
         default: return WR_DSCP;
      endcase
   endfunction : wmask

   task automatic print_verdict;
      if (num_errors == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict

   task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr, input logic [7:0] data);
      apb_note_type nt;
      logic [4:0] k;
      logic ok;
      int t;
      k = addr[6:2];
      ok = addr[1:0] == 2'b00 && addr[11:2] >= IDX_UNKNOWN_MCAST && addr[11:2] <= IDX_DSCP_LAST
         && !(addr[11:2] > IDX_RATE_TAG && addr[11:2] < IDX_DSCP_BASE);
      nt.rd = !wr;
      nt.err = !ok;
      nt.data = ok ? sh[k] : 8'h00;
      note_q.push_back(nt);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= {24'($urandom()), data};
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (t >= 20) num_errors++;
      if (wr && ok) sh[k] = (data & wmask(k)) | (sh[k] & ~wmask(k));
   endtask : apb

   task automatic frame(input frame_class_type c, input logic [MAC_W-1:0] mac);
      frame_req_type r;
      frame_resp_type x;
      logic [7:0] m;
      logic [7:0] b;
      r.valid = 1'b1;
      r.cls = c;
      r.src_port = 3'($urandom_range(4));
      r.dst_mac = mac;
      r.tos = 8'($urandom());
      r.default_map = 5'($urandom());
      case (c)
         cls_unknown_mcast: m = sh[4];
         cls_unknown_vid: m = sh[5];
         cls_unknown_ip_mcast: m = sh[6];
         default: m = 8'h00;
      endcase
      x.valid = 1'b1;
      x.fwd_map = (m[FWD_EN_BIT] ? m[4:0] : r.default_map) & MAP_PORT_MASK;
      x.self_dropped = sh[6][SELF_EN_BIT] && mac == own_mac;
      if (x.self_dropped) x.fwd_map = 5'h00;
      b = sh[{1'b1, r.tos[7:4]}];
      x.prio = b[{r.tos[3:2], 1'b0} +: 2];
      for (int i = 0; i < PORTS; i++) begin
         x.tag_insert[i] = sh[7][TAG_SEL_BIT] ? tag_by_source[i][r.src_port] : tag_by_port[i];
      end
      resp_q.push_back(x);
      @(posedge pclk);
      req <= r;
      @(posedge pclk);
      req.valid <= 1'b0;
   endtask : frame

   task automatic frames_all(input logic [MAC_W-1:0] mac);
      for (int c = 0; c < 4; c++) frame(frame_class_type'(c), mac);
   endtask : frames_all

   task automatic wait_pulse;
      int t;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (rate_period_pulse !== 1'b1 && t < 100);
      if (t >= 100) num_errors++;
   endtask : wait_pulse

   // answer monitor: every apb answer takes the oldest note, every frame decision the oldest expected response
   always @(posedge pclk) begin
      if (pready === 1'b1 && note_q.size() > 0) begin
         n = note_q.pop_front();
         compares++;
         if (pslverr !== n.err || (n.rd && prdata !== {24'h000000, n.data})) begin
            $display("[FAIL] %0t apb answer wrong", $time);
            num_errors++;
         end
      end
      if (resp.valid === 1'b1 && resp_q.size() > 0) begin
         e = resp_q.pop_front();
         compares++;
         if (resp !== e) begin
            $display("[FAIL] %0t frame decision wrong", $time);
            num_errors++;
         end
      end
      if (rate_period_pulse === 1'b1) begin
         if (per_q.size() > 0) begin
            compares++;
            if (cnt != per_q.pop_front()) begin
               $display("[FAIL] %0t period tick spacing wrong", $time);
               num_errors++;
            end
         end
         cnt = 1;
      end else cnt++;
   end

   initial begin
      #200000;
      num_errors++;
      print_verdict();
   end

   initial begin
      rnd = $urandom(32'h887D);
      for (int i = 0; i < 32; i++) sh[i] = RST_DSCP;
      sh[4] = RST_UNKNOWN_MCAST;
      sh[5] = RST_UNKNOWN_VID;
      sh[6] = RST_SELF_IPMC;
      sh[7] = RST_RATE_TAG;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      own_mac <= {16'($urandom()), 32'($urandom())};
      tag_by_source <= 25'($urandom());
      tag_by_port <= 5'($urandom());
      for (int i = 4; i < 32; i++) if (i < 8 || i >= 16) apb(0, {5'b00100, 5'(i), 2'b00}, 0);
      apb(0, 12'h220, 0);
      apb(1, 12'h211, 8'hFF);
      apb(0, 12'h000, 0);
      for (int i = 4; i < 8; i++) apb(1, {5'b00100, 5'(i), 2'b00}, 8'hFF);
      for (int i = 4; i < 8; i++) apb(0, {5'b00100, 5'(i), 2'b00}, 0);
      apb(1, 12'h21C, RST_RATE_TAG);
      for (int j = 0; j < 12; j++) begin
         logic [4:0] v;
         v = j / 2 == 0 ? 5'h00 : j / 2 == 1 ? 5'h01 : j / 2 == 2 ? 5'h03 :
            j / 2 == 3 ? 5'h07 : j / 2 == 4 ? 5'h1F : 5'h08;
         for (int i = 4; i < 7; i++) apb(1, {5'b00100, 5'(i), 2'b00}, {2'b10, j[0], v});
         frames_all(own_mac);
      end
      apb(1, 12'h218, 8'h7F);
      frames_all(own_mac);
      frames_all(~own_mac);
      apb(1, 12'h218, 8'h3F);
      frames_all(own_mac);
      for (int i = 16; i < 32; i++) apb(1, {5'b00100, 5'(i), 2'b00}, 8'($urandom()));
      repeat (20) frame(cls_known, ~own_mac);
      for (int i = 0; i < 4; i++) begin
         apb(1, 12'h21C, 8'h10 | 8'(i << 2));
         repeat (2) @(posedge pclk);
         compares++;
         if (queue_based_rate !== sh[7][QUEUE_RATE_BIT]) begin
            $display("[FAIL] %0t rate limit mode wrong", $time);
            num_errors++;
         end
         repeat (3) frame(cls_unknown_vid, ~own_mac);
      end
      for (int p = 0; p < 4; p++) begin
         apb(1, 12'h21C, 8'(p << PERIOD_LSB));
         // let a tick from the old period and the restart pass first
         repeat (2) @(posedge pclk);
         wait_pulse();
         @(posedge pclk);
         per_q.push_back(p == 0 ? P16 : p == 1 ? P64 : P256);
         wait_pulse();
         @(posedge pclk);
      end
      repeat (3) @(posedge pclk);
      print_verdict();
   end
endmodule : test_fwd_ctrl_regs
